// *** logic/adcfr_buf.sv ***
// Two-entry valid/ready buffer that carries results to the user.
`default_nettype none
module adcfr_buf #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage entries.
  logic [AW-1:0]    wr_q;           // Write index.
  logic [AW-1:0]    rd_q;           // Read index.
  logic [AW:0]      cnt_q;          // Number of entries held.
  logic             push;
  logic             pop;

  // Full and empty come straight from the fill count, so neither can lie.
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // The head entry is registered so the data output comes from a flip-flop.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      out_data <= '0;
    end
    else if (pop && cnt_q > (AW+1)'(1))
    begin
      out_data <= mem_q[(rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1];
    end
    else if (push && (cnt_q == '0 || (pop && cnt_q == (AW+1)'(1))))
    begin
      out_data <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/adcfr_host.sv ***
// Host side framing controller: makes the serial clock, frames and spaces conversions.
`default_nettype none
module adcfr_host
  import adcfr_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          rst,
  // User command stream.
  input  wire logic          cmd_valid,
  output logic               cmd_ready,
  input  wire adcfr_cmd_type cmd,
  output logic               cmd_refused,
  // User result stream.
  output logic               res_valid,
  input  wire logic          res_ready,
  output adcfr_res_type      res,
  // Tracked device state.
  output logic               powered,
  output logic               seq_active,
  // Device pins.
  output logic               sclk,
  output logic               host_tx_frame_sync_n,
  output logic               din,
  input  wire logic          dout
);
  // Registers end in _q; the rest are decodes of this cycle's state.
  adcfr_state_type state_q;          // Frame state.
  logic [3:0]      div_q;            // Serial clock divider phase.
  logic            sclk_q;           // Serial clock level.
  logic            fall_tick;        // Serial clock falls after this cycle.
  logic            rise_tick;        // Serial clock rises after this cycle.
  logic            dout_m_q;         // Synchroniser first stage.
  logic            dout_s_q;         // Synchronised device data.
  logic            cs_n_q;           // Frame sync, also the device select.
  logic            din_q;            // Data toward the device.
  logic [15:0]     tx_q;             // Outgoing word.
  logic [15:0]     rx_q;             // Incoming word.
  logic [4:0]      bits_q;           // Falling edges seen in this frame.
  logic            extra_q;          // Current frame is an extra write.
  logic [7:0]      since_conv_q;     // Serial periods since the last conversion start.
  logic [7:0]      since_end_q;      // Serial periods since the last select rise.
  logic            pwr_wait_q;       // A power-up settling wait is running.
  logic            powered_q;        // Device last commanded to normal power.
  logic            seq_q;            // Sequencer believed active.
  logic            frame_end;        // Select rises after this cycle.
  logic            refuse;           // Command at the head is refused.
  logic            go;               // Command at the head may start now.
  logic            buf_in_ready;     // Result buffer has room.
  logic            buf_push;         // Result written to the buffer.
  adcfr_res_type   buf_in;           // Result taken from the frame.

  // Divider phase gives one-cycle ticks just before each serial clock edge.
  // The high half comes first after reset, so the first fall is half a period in,
  // and a frame can only open on a rise, never in the middle of a period.
  assign fall_tick = (div_q == DIV_HALF);
  assign rise_tick = (div_q == DIV_LAST);
  assign frame_end = (state_q == ADCFR_FRAME) && rise_tick && (bits_q == FRAME_BITS);

  // The clock never stops between frames; the frame sync alone marks a transfer.
  // This keeps the divider trivial at the cost of a little idle switching.
  // free-running clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_q  <= 4'h0;
      sclk_q <= 1'h1;
    end
    else
    begin
      div_q <= rise_tick ? 4'h0 : div_q + 4'h1;
      if (fall_tick)
      begin
        sclk_q <= 1'h0;
      end
      else if (rise_tick)
      begin
        sclk_q <= 1'h1;
      end
    end
  end

  // The device data pin is foreign to this clock, so it passes two flops first.
  // The lag of two cycles is harmless: the first bit stands five cycles before it is taken, the rest ten.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dout_m_q <= 1'h0;
      dout_s_q <= 1'h0;
    end
    else
    begin
      dout_m_q <= dout;
      dout_s_q <= dout_m_q;
    end
  end

  // Start decision, taken only on a rise tick so frames sit on the clock grid.
  // A refused command never waits for spacing; it is dropped on the first rise tick
  // in idle, so the user learns of the mistake at once.
  always_comb
  begin
    // Defaults keep both strobes low outside a rise tick in idle.
    refuse = 1'h0;
    go     = 1'h0;
    if (state_q == ADCFR_IDLE && rise_tick && cmd_valid)
    begin
      if (cmd.extra_write)
      begin
        refuse = seq_q;
        go     = !seq_q && (since_end_q >= QUIET_SCLK);
      end
      else
      begin
        // A conversion waits for spacing, settling and room for its result.
        // power-up write first
        refuse = !powered_q;
        go     = powered_q && (since_conv_q >= CONV_GAP_SCLK)
                 && (since_end_q >= QUIET_SCLK)
                 && (!pwr_wait_q || since_end_q >= PWRUP_SCLK)
                 && buf_in_ready;
      end
    end
  end

  // Refusals consume the command so a bad request cannot block the queue.
  // The price is that a refused command is lost; the user must watch cmd_refused.
  assign cmd_ready   = go || refuse;
  assign cmd_refused = refuse;

  // Frame sequencing and shifting.
  // The word is loaded whole at the start, so cmd may change once it is taken.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ADCFR_IDLE;
      cs_n_q  <= 1'h1;
      din_q   <= 1'h0;
      tx_q    <= 16'h0000;
      rx_q    <= 16'h0000;
      bits_q  <= 5'h00;
      extra_q <= 1'h0;
    end
    else
    begin
      unique case (state_q)
        ADCFR_IDLE:
        begin
          // Stay idle until the start decision lets the head command go.
          if (go)
          begin
            cs_n_q  <= 1'h0;
            tx_q    <= cmd.word;
            din_q   <= cmd.word[15];
            bits_q  <= 5'h00;
            extra_q <= cmd.extra_write;
            state_q <= ADCFR_FRAME;
          end
        end
        ADCFR_FRAME:
        begin
          if (fall_tick && bits_q != FRAME_BITS)
          begin
            rx_q   <= {rx_q[14:0], dout_s_q};
            bits_q <= bits_q + 5'h01;
          end
          // Ending on a rise tick gives the sixteenth bit a full low half first.
          if (frame_end)
          begin
            cs_n_q  <= 1'h1;
            state_q <= ADCFR_IDLE;
          end
          else if (rise_tick)
          begin
            // bit changes away from device sampling edge
            tx_q  <= {tx_q[14:0], 1'h0};
            din_q <= tx_q[14];
          end
        end
      endcase
    end
  end

  // Spacing counters, counted in whole serial periods and saturated.
  // since_end_q counts only in idle, so a running frame never looks like quiet time.
  // Both stop at the largest threshold they are compared with, so neither can wrap.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      since_conv_q <= CONV_GAP_SCLK;
      since_end_q  <= PWRUP_SCLK;
    end
    else if (rise_tick)
    begin
      if (go && !cmd.extra_write)
      begin
        since_conv_q <= 8'h01;
      end
      else if (since_conv_q < CONV_GAP_SCLK)
      begin
        since_conv_q <= since_conv_q + 8'h01;
      end
      if (frame_end)
      begin
        since_end_q <= 8'h00;
      end
      else if (state_q == ADCFR_IDLE && since_end_q < PWRUP_SCLK)
      begin
        since_end_q <= since_end_q + 8'h01;
      end
    end
  end

  // Device state is taken when a write frame starts, since frames always run all
  // sixteen clocks and so never leave the control word half written.
  // A write to any power mode but normal clears the settling wait as well.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      powered_q  <= POWERED_RST;
      seq_q      <= SEQ_RST;
      pwr_wait_q <= 1'h0;
    end
    else if (state_q == ADCFR_IDLE && go && cmd.word[WRITE_BIT])
    begin
      powered_q  <= ({cmd.word[PM_HI_BIT], cmd.word[PM_LO_BIT]} == PM_NORMAL);
      pwr_wait_q <= ({cmd.word[PM_HI_BIT], cmd.word[PM_LO_BIT]} == PM_NORMAL);
      seq_q      <= cmd.word[SEQ_BIT];
    end
    else if (pwr_wait_q && since_end_q >= PWRUP_SCLK && state_q == ADCFR_IDLE)
    begin
      // Settling time has run out; conversions may start again.
      pwr_wait_q <= 1'h0;
    end
  end

  // Extra writes still clock in sixteen bits, but nothing is kept from them.
  // extra-write answer dropped
  assign buf_push = frame_end && !extra_q;
  assign buf_in   = adcfr_res_type'(rx_q[13:0]);

  // Results wait here; a full buffer holds off the next conversion start.
  // Two entries let one result wait while the next conversion fills the other.
  adcfr_buf #(
    .WIDTH (RES_W),
    .DEPTH (2)
  ) u_res_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (buf_push),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res)
  );

  // Pins and status come from flip-flops.
  // No pin is combinational, so nothing glitches toward the device.
  assign sclk                 = sclk_q;
  assign host_tx_frame_sync_n = cs_n_q;
  assign din                  = din_q;
  assign powered              = powered_q;
  assign seq_active           = seq_q;
endmodule
`default_nettype wire

// *** pkg/adcfr_pkg.sv ***
// Shared constants and types for the converter framing controller.
`default_nettype none
package adcfr_pkg;
  // Core clock period and serial clock divider (core cycles per serial clock).
  localparam int          CLK_NS     = 5;
  localparam int          SCLK_DIV   = 10;
  localparam int          SCLK_NS    = CLK_NS * SCLK_DIV;
  localparam logic [3:0]  DIV_LAST   = 4'(SCLK_DIV - 1);
  localparam logic [3:0]  DIV_HALF   = 4'(SCLK_DIV / 2 - 1);

  // Frame length in serial clocks, in both directions.
  localparam logic [4:0]  FRAME_BITS = 5'h10;

  // Timing in nanoseconds as specified, then as whole serial clock periods (rounded up).
  localparam int          CONV_GAP_NS    = 5000;
  localparam int          PWRUP_NS       = 1000;
  localparam int          QUIET_NS       = 50;
  localparam logic [7:0]  CONV_GAP_SCLK  = 8'((CONV_GAP_NS + SCLK_NS - 1) / SCLK_NS);
  localparam logic [7:0]  PWRUP_SCLK     = 8'((PWRUP_NS + SCLK_NS - 1) / SCLK_NS);
  localparam logic [7:0]  QUIET_SCLK_RAW = 8'((QUIET_NS + SCLK_NS - 1) / SCLK_NS);
  localparam logic [7:0]  QUIET_SCLK     = (QUIET_SCLK_RAW == 8'h00) ? 8'h01 : QUIET_SCLK_RAW;

  // Control word field positions.
  localparam int          WRITE_BIT  = 15;
  localparam int          SEQ_BIT    = 14;
  localparam int          PM_HI_BIT  = 9;
  localparam int          PM_LO_BIT  = 8;
  localparam logic [1:0]  PM_NORMAL  = 2'h3;

  // Reset values of the tracked device state.
  localparam logic        POWERED_RST = 1'h0;
  localparam logic        SEQ_RST     = 1'h0;

  // A request from the user: a conversion frame, or an extra write whose answer is dropped.
  typedef struct packed {
    logic        extra_write;
    logic [15:0] word;
  } adcfr_cmd_type;

  // A result word: channel tag bits then the 12-bit value (leading zeros dropped).
  typedef struct packed {
    logic        channel_tag_hi;
    logic        channel_tag_lo;
    logic [11:0] value;
  } adcfr_res_type;

  localparam int RES_W = $bits(adcfr_res_type);

  typedef enum logic [0:0] {
    ADCFR_IDLE,
    ADCFR_FRAME
  } adcfr_state_type;
endpackage
`default_nettype wire

// *** sim/adcfr_dev_model.sv ***
// Behavioural converter answering the host frames.
`default_nettype none
module adcfr_dev_model (
  // Serial pins.
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic din,
  output var logic  dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] out_q;  // Word shifted out.
  logic [15:0] ctl_q;  // Bits shifted in.
  logic [4:0]  n_q;    // Falls in this frame.
  logic [1:0]  ch_q;   // Sequence channel.
  logic [9:0]  cnt_q;  // Frame count, used as the sample.
  logic        seq_q;  // Sequencer on.
  logic        pwr_q;  // Powered; starts shut down.
  initial
  begin
    {out_q, ctl_q, n_q, ch_q, cnt_q, seq_q, pwr_q, dout} = '0;
  end
  // sample on select fall.
  // A released line shows its inverse, so stale bits never pass as data.
  always @(negedge cs_n)
  begin
    ch_q = ch_q + {1'b0, seq_q};
    cnt_q = cnt_q + 10'h001;
    n_q = 5'h00;
    out_q = {2'h0, ch_q, ch_q, cnt_q};
    dout = pwr_q ? out_q[15] : ~dout;
  end
  always @(negedge sclk)
  begin
    if (!cs_n && n_q != 5'h10)
    begin
      n_q = n_q + 5'h01;
      ctl_q = {ctl_q[14:0], din};
      out_q = {out_q[14:0], 1'b0};
      dout = (pwr_q && n_q != 5'h10) ? out_q[15] : ~dout;
    end
  end
  always @(posedge cs_n)
  begin
    if (n_q == 5'h10 && ctl_q[15])
    begin
      seq_q = ctl_q[14];
      pwr_q = ctl_q[9:8] == 2'h3;
    end
  end
endmodule
`default_nettype wire

// *** sim/adcfr_host_asserts.sv ***
// Port-level property checks for the framing controller.
`default_nettype none
module adcfr_host_chk
  import adcfr_pkg::*;
(
  // Clock and reset.
  input wire logic          clk,
  input wire logic          rst,
  // Command side.
  input wire logic          cmd_valid,
  input wire logic          cmd_ready,
  input wire adcfr_cmd_type cmd,
  input wire logic          cmd_refused,
  // State and pins.
  input wire logic          powered,
  input wire logic          seq_active,
  input wire logic          sclk,
  input wire logic          host_tx_frame_sync_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Least counter values each spacing rule allows; the counters lag the pins by one
  // or two samples, which the subtracted cycles account for.
  localparam logic [9:0] CONV_MIN  = 10'(CONV_GAP_NS / CLK_NS - 1);
  localparam logic [7:0] QUIET_MIN = 8'(QUIET_NS / CLK_NS - 1);
  localparam logic [7:0] PWRUP_MIN = 8'(PWRUP_NS / CLK_NS - 2);
  logic       cs;      // Select pin.
  logic       take;    // Command starts a frame.
  logic       conv;    // Command starts a conversion.
  logic [9:0] conv_q;  // Cycles since a conversion start.
  logic [7:0] rise_q;  // Cycles since select rose.
  logic [7:0] pwr_q;   // Cycles since a power-up write ended.
  logic [4:0] fall_q;  // Clock falls in this frame.
  logic       pw_q;    // Frame is a power-up write.
  logic       cs_q;    // Select last cycle.
  logic       sc_q;    // Clock last cycle.
  assign cs = host_tx_frame_sync_n;
  assign take = cmd_valid && cmd_ready && !cmd_refused;
  assign conv = take && !cmd.extra_write;
  // Counters saturate so a long idle never wraps into a short gap.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {conv_q, rise_q, pwr_q} <= {10'h3FF, 8'hFF, 8'hFF};
      {fall_q, pw_q, cs_q, sc_q} <= {5'h00, 1'b0, 1'b1, 1'b1};
    end
    else
    begin
      cs_q <= cs;
      sc_q <= sclk;
      conv_q <= conv ? 10'h000 : conv_q + {9'h000, conv_q != 10'h3FF};
      rise_q <= (!cs_q && cs) ? 8'h00 : rise_q + {7'h00, rise_q != 8'hFF};
      pwr_q <= (!cs_q && cs && pw_q) ? 8'h00 : pwr_q + {7'h00, pwr_q != 8'hFF};
      fall_q <= (cs_q && !cs) ? 5'h00 : fall_q + {4'h0, sc_q && !sclk && !cs};
      if (take)
        pw_q <= cmd.word[WRITE_BIT] && cmd.word[PM_HI_BIT:PM_LO_BIT] == PM_NORMAL;
    end
  end
  sequence s_high_half;
    sclk [*5] ##1 !sclk;
  endsequence
  sequence s_low_half;
    !sclk [*5] ##1 sclk;
  endsequence
  a_sclk_high_half: assert property ($rose(sclk) |-> s_high_half)
    else $error("Serial clock high half has the wrong length.");
  a_sclk_low_half: assert property ($fell(sclk) |-> s_low_half)
    else $error("Serial clock low half has the wrong length.");
  a_frame_start: assert property ($fell(cs) |-> $past(take) && $rose(sclk))
    else $error("Select fell without a taken command.");
  a_frame_sixteen: assert property ($rose(cs) |-> fall_q == 5'h10)
    else $error("Frame did not hold sixteen clock falls.");
  a_conv_spacing: assert property (conv |-> conv_q >= CONV_MIN)
    else $error("Conversions closer than the minimum spacing.");
  a_quiet_time: assert property ($fell(cs) |-> rise_q >= QUIET_MIN)
    else $error("Select fell too soon after it rose.");
  a_powerup_wait: assert property (conv |-> pwr_q >= PWRUP_MIN)
    else $error("Conversion too soon after a power-up write.");
  a_refuse_off: assert property (cmd_valid && cmd_ready && !cmd.extra_write && !powered
    |-> cmd_refused)
    else $error("Conversion taken while shut down.");
  a_refuse_seq: assert property (cmd_valid && cmd_ready && cmd.extra_write && seq_active
    |-> cmd_refused)
    else $error("Extra write taken while sequencing.");
endmodule
`default_nettype wire

// *** sim/adcfr_host_test.sv ***
// Self-checking bench for the converter framing controller.
`default_nettype none
module adcfr_host_test
  import adcfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, res_ready = 1'b0;
  logic          stall = 1'b0, sync_q = 1'b1, m_seq = 1'b0, m_pwr = 1'b0;
  logic          cmd_ready, cmd_refused, res_valid, powered, seq_active;
  logic          sclk, sync_n, din, dout;
  adcfr_cmd_type cmd = '0;
  adcfr_res_type res;
  logic [13:0]   exp_q[$];    // Results still owed.
  logic [9:0]    m_cnt = '0;  // Mirror of device frame count.
  logic [1:0]    m_ch = '0;   // Mirror of device channel.
  int            failures = 0, samples_checked = 0, seed = 88467;
  int            now = 0, last = 0, gap = 0, frames = 0, fs = 0, i = 0;
  always #2.5 clk = ~clk;
  adcfr_host uut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .cmd_refused(cmd_refused), .res_valid(res_valid), .res_ready(res_ready),
    .res(res), .powered(powered), .seq_active(seq_active), .sclk(sclk),
    .host_tx_frame_sync_n(sync_n), .din(din), .dout(dout));
  adcfr_dev_model dev (.sclk(sclk), .cs_n(sync_n), .din(din), .dout(dout));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Bounded wait for a clock edge; a used-up bound ends the run.
  task automatic tick(input int lim);
    if (++i > lim)
    begin
      failures++;
      wrap_up;
    end
    @(posedge clk);
    #1;
  endtask
  // Expected refusal and result word, worked out from the rules alone.
  function automatic logic exp_refuse(input logic ext, input logic seq, input logic pwr);
    return ext ? seq : !pwr;
  endfunction
  function automatic logic [13:0] exp_res(input logic [1:0] ch, input logic [9:0] cnt);
    return {ch, ch, cnt};
  endfunction
  // Presents one command and mirrors what the device will do with it.
  task automatic send(input logic ext, input logic [15:0] w);
    logic ref_exp;
    i = 0;
    cmd_valid = 1'b1;
    cmd = {ext, w};
    #1;
    while (cmd_ready !== 1'b1)
      tick(6000);
    ref_exp = exp_refuse(ext, m_seq, m_pwr);
    check(cmd_refused, ref_exp, "refused");
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    if (!ref_exp)
    begin
      m_cnt = m_cnt + 10'h001;
      m_ch = m_ch + {1'b0, m_seq};
      if (!ext)
        exp_q.push_back(exp_res(m_ch, m_cnt));
      if (w[15])
        {m_seq, m_pwr} = {w[14], w[9:8] == PM_NORMAL};
    end
    @(posedge clk);
    #1;
    check({powered, seq_active}, {m_pwr, m_seq}, "state");
  endtask
  task automatic drain;
    i = 0;
    while (exp_q.size() != 0)
      tick(5000);
  endtask
  // Random take stalls, driven just after each edge.
  always @(posedge clk)
  begin
    #1;
    res_ready = !stall && $random(seed) % 2 != 0;
  end
  // Scores results and times frame starts.
  always @(posedge clk)
  begin
    if (!rst && res_valid && res_ready)
      check(res, exp_q.size() != 0 ? exp_q.pop_front() : 14'h3FFF, "res");
    if (sync_q && !sync_n)
    begin
      frames++;
      gap = now - last;
      if (last != 0)
        check(gap % SCLK_DIV, 0, "gap_phase");
      last = now;
    end
    sync_q = sync_n;
    now++;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    send(1'b0, 16'h0000);
    $display("test refuse_off done");
    send(1'b1, 16'h8300);
    for (int k = 0; k < 6; k++)
    begin
      send(1'b0, {1'b0, 15'($random(seed))});
      if (k > 0)
        check(gap, 1000, "gap");
    end
    $display("test stream done");
    send(1'b0, 16'hC300);
    repeat (5) send(1'b0, 16'h0000);
    send(1'b1, 16'h8300);
    send(1'b0, 16'h8300);
    $display("test sequence done");
    drain;
    stall = 1'b1;
    send(1'b0, 16'h0000);
    send(1'b0, 16'h0000);
    fs = frames;
    fork
      begin
        repeat (2500) @(posedge clk);
        #1;
        check(frames, fs, "frames");
        check(res_valid, 1'b1, "res_valid");
        stall = 1'b0;
      end
    join_none
    send(1'b0, 16'h0000);
    drain;
    $display("test stall done");
    // Power down by a conversion write, see a conversion refused, then wake again.
    send(1'b0, 16'h8200);
    send(1'b0, 16'h0000);
    send(1'b1, 16'h8300);
    send(1'b0, 16'h0000);
    drain;
    $display("test power_down done");
    wrap_up;
  end
endmodule
bind adcfr_host adcfr_host_chk chk (.clk, .rst, .cmd_valid, .cmd_ready, .cmd, .cmd_refused,
  .powered, .seq_active, .sclk, .host_tx_frame_sync_n);
`default_nettype wire
